// File: rtl/charger_limit_pkg.sv
// Package: constants and types for the input current limit control byte and its serial slave.
// Assumes one 25 MHz clock domain; all users refer to names as charger_limit_pkg::name.
package charger_limit_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] LIMIT_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] LIMIT_CTRL_RESET = 8'h17;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [6:0] SLAVE_ADDRESS_DEFAULT = 7'h0A;

   // Field layout, bit 7 down to bit 0
   typedef struct packed {
      logic input_isolation_enable;
      logic [1:0] indicator_pin_function_select;
      logic [4:0] input_current_limit_code;
   } limit_ctrl_t;

   // Indicator pin function codes
   localparam logic [1:0] IND_FOLLOW_CHARGE = 2'h0;
   localparam logic [1:0] IND_FOLLOW_CUSTOM = 2'h1;

   // ----------------------------------------------------------------
   // Limit mapping, milliamperes
   // ----------------------------------------------------------------
   localparam int LIMIT_MA_WIDTH = 12;
   localparam logic [11:0] LIMIT_OFFSET_MA = 12'h064;
   localparam logic [11:0] LIMIT_STEP_MA = 12'h064;
   localparam logic [11:0] LIMIT_TOP_MA = 12'hED8;
   localparam logic [4:0] LIMIT_CODE_TOP = 5'h1F;

   // ----------------------------------------------------------------
   // Serial protocol
   // ----------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] FIRST_BIT_SENT = 4'h1;

   typedef enum {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_PTR,
      ST_ACK_PTR,
      ST_WDATA,
      ST_ACK_WDATA,
      ST_RDATA,
      ST_RACK
   } serial_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } bus_lines_t;

endpackage : charger_limit_pkg

// File: rtl/line_synchronizer.sv
// Three-stage synchroniser with agreement filter for the two serial bus lines.
// Assumes the lines idle high and are asynchronous to sys_clk.
`timescale 1ns/1ps
module line_synchronizer
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Raw and filtered lines
   input wire charger_limit_pkg::bus_lines_t raw_lines,
   output charger_limit_pkg::bus_lines_t clean_lines
);

   charger_limit_pkg::bus_lines_t stage1_reg;
   charger_limit_pkg::bus_lines_t stage2_reg;
   charger_limit_pkg::bus_lines_t stage3_reg;
   charger_limit_pkg::bus_lines_t clean_reg;

   // ----------------------------------------------------------------
   // Stages; the first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         stage1_reg <= '1;
         stage2_reg <= '1;
         stage3_reg <= '1;
      end
      else
      begin
         stage1_reg <= raw_lines;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // Per line, a change counts only when stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         clean_reg <= '1;
      else
      begin
         if (stage2_reg.scl == stage3_reg.scl)
            clean_reg.scl <= stage3_reg.scl;
         if (stage2_reg.sda == stage3_reg.sda)
            clean_reg.sda <= stage3_reg.sda;
      end
   end

   assign clean_lines = clean_reg;

endmodule : line_synchronizer

// File: rtl/limit_decoder.sv
// Converts the five-bit input current limit code into milliamperes.
// Assumes the code comes from a register on the same clock; result is registered.
`timescale 1ns/1ps
module limit_decoder
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Code in, limit out
   input wire logic [4:0] limit_code,
   output logic [11:0] limit_ma
);

   logic [11:0] limit_ma_reg;

   // ----------------------------------------------------------------
   // Mapping
   // ----------------------------------------------------------------
   function automatic logic [11:0] code_to_ma(input logic [4:0] code);
      logic [23:0] product;
      product = {7'h00, code} * {12'h000, charger_limit_pkg::LIMIT_STEP_MA};
      if (code == charger_limit_pkg::LIMIT_CODE_TOP)
         return charger_limit_pkg::LIMIT_TOP_MA;
      return charger_limit_pkg::LIMIT_OFFSET_MA + product[11:0];
   endfunction : code_to_ma

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         limit_ma_reg <= code_to_ma(charger_limit_pkg::LIMIT_CTRL_RESET[4:0]);
      else
         limit_ma_reg <= code_to_ma(limit_code);
   end

   assign limit_ma = limit_ma_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_code_top_held;
      (limit_code == charger_limit_pkg::LIMIT_CODE_TOP) ##1 (limit_code == charger_limit_pkg::LIMIT_CODE_TOP);
   endsequence

   sequence s_code_linear_held;
      (limit_code != charger_limit_pkg::LIMIT_CODE_TOP) ##1 $stable(limit_code);
   endsequence

   a_limit_top_value: assert property (@(posedge sys_clk) disable iff (rst)
      s_code_top_held |-> limit_ma == 12'hED8)
      else $error("top code does not give the top limit");

   a_limit_linear_value: assert property (@(posedge sys_clk) disable iff (rst)
      s_code_linear_held |-> limit_ma == 12'h064 + 12'(limit_code) * 12'h064)
      else $error("linear limit mapping is wrong");

endmodule : limit_decoder

// File: rtl/charger_input_limit_register.sv
// Input current limit control byte with its serial bus slave and indicator pin drive.
// Assumes host lines arrive asynchronously; detection, watchdog and defaults-reset events
// and the charge state come from logic on sys_clk.
`timescale 1ns/1ps
module charger_input_limit_register
#(
   parameter logic [6:0] SLAVE_ADDRESS = charger_limit_pkg::SLAVE_ADDRESS_DEFAULT
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Serial bus, open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Device events
   input wire logic detect_done,
   input wire logic [4:0] detected_code,
   input wire logic register_reset,
   input wire logic watchdog_expired,
   // Indicator sources
   input wire logic charge_active,
   input wire logic indicator_custom,
   // Indicator pin, open drain
   output logic stat_out,
   output logic stat_oe,
   // Controls to the power stage
   output logic input_isolated_mode,
   output logic [11:0] input_limit_ma
);

   charger_limit_pkg::limit_ctrl_t ctrl_reg;
   charger_limit_pkg::serial_state_t state_reg;
   charger_limit_pkg::bus_lines_t raw_lines;
   charger_limit_pkg::bus_lines_t clean_lines;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic read_dir_reg;
   logic master_nack_reg;
   logic sda_oe_reg;
   logic stat_oe_reg;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic host_write;
   logic [7:0] first_read_byte;

   // ----------------------------------------------------------------
   // Line conditioning and bus events
   // ----------------------------------------------------------------
   assign raw_lines.scl = scl_in;
   assign raw_lines.sda = sda_in;

   line_synchronizer line_sync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw_lines(raw_lines),
      .clean_lines(clean_lines)
   );

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_prev_reg <= clean_lines.scl;
         sda_prev_reg <= clean_lines.sda;
      end
   end

   assign scl_rise = clean_lines.scl & ~scl_prev_reg;
   assign scl_fall = ~clean_lines.scl & scl_prev_reg;
   assign bus_start = clean_lines.scl & scl_prev_reg & sda_prev_reg & ~clean_lines.sda;
   assign bus_stop = clean_lines.scl & scl_prev_reg & ~sda_prev_reg & clean_lines.sda;

   // Only offset zero is mapped; other offsets read as zero and drop writes
   function automatic logic [7:0] read_byte(input logic [7:0] ptr, input charger_limit_pkg::limit_ctrl_t ctrl);
      if (ptr == charger_limit_pkg::LIMIT_CTRL_OFFSET)
         return ctrl;
      return charger_limit_pkg::UNMAPPED_READ;
   endfunction : read_byte

   assign first_read_byte = read_byte(ptr_reg, ctrl_reg);
   assign host_write = (state_reg == charger_limit_pkg::ST_WDATA) && scl_fall
      && (bit_cnt_reg == charger_limit_pkg::BITS_PER_BYTE);

   // ----------------------------------------------------------------
   // Serial slave
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_reg <= charger_limit_pkg::ST_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= '0;
         ptr_reg <= charger_limit_pkg::LIMIT_CTRL_OFFSET;
         read_dir_reg <= 1'b0;
         master_nack_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
      end
      else if (bus_start)
      begin
         // A repeated start keeps the register pointer
         state_reg <= charger_limit_pkg::ST_ADDR;
         bit_cnt_reg <= '0;
         sda_oe_reg <= 1'b0;
      end
      else if (bus_stop)
      begin
         state_reg <= charger_limit_pkg::ST_IDLE;
         sda_oe_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            charger_limit_pkg::ST_IDLE:
            begin
               sda_oe_reg <= 1'b0;
            end
            charger_limit_pkg::ST_ADDR, charger_limit_pkg::ST_PTR, charger_limit_pkg::ST_WDATA:
            begin
               if (scl_rise && bit_cnt_reg < charger_limit_pkg::BITS_PER_BYTE)
               begin
                  shift_reg <= {shift_reg[6:0], clean_lines.sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               else if (scl_fall && bit_cnt_reg == charger_limit_pkg::BITS_PER_BYTE)
               begin
                  bit_cnt_reg <= '0;
                  if (state_reg == charger_limit_pkg::ST_ADDR)
                  begin
                     if (shift_reg[7:1] == SLAVE_ADDRESS)
                     begin
                        read_dir_reg <= shift_reg[0];
                        sda_oe_reg <= 1'b1;
                        state_reg <= charger_limit_pkg::ST_ACK_ADDR;
                     end
                     else
                        state_reg <= charger_limit_pkg::ST_IDLE;
                  end
                  else if (state_reg == charger_limit_pkg::ST_PTR)
                  begin
                     ptr_reg <= shift_reg;
                     sda_oe_reg <= 1'b1;
                     state_reg <= charger_limit_pkg::ST_ACK_PTR;
                  end
                  else
                  begin
                     ptr_reg <= ptr_reg + 8'h01;
                     sda_oe_reg <= 1'b1;
                     state_reg <= charger_limit_pkg::ST_ACK_WDATA;
                  end
               end
            end
            charger_limit_pkg::ST_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  if (read_dir_reg)
                  begin
                     sda_oe_reg <= ~first_read_byte[7];
                     shift_reg <= {first_read_byte[6:0], 1'b0};
                     bit_cnt_reg <= charger_limit_pkg::FIRST_BIT_SENT;
                     state_reg <= charger_limit_pkg::ST_RDATA;
                  end
                  else
                  begin
                     sda_oe_reg <= 1'b0;
                     state_reg <= charger_limit_pkg::ST_PTR;
                  end
               end
            end
            charger_limit_pkg::ST_ACK_PTR, charger_limit_pkg::ST_ACK_WDATA:
            begin
               if (scl_fall)
               begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= charger_limit_pkg::ST_WDATA;
               end
            end
            charger_limit_pkg::ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_reg == charger_limit_pkg::BITS_PER_BYTE)
                  begin
                     sda_oe_reg <= 1'b0;
                     ptr_reg <= ptr_reg + 8'h01;
                     state_reg <= charger_limit_pkg::ST_RACK;
                  end
                  else
                  begin
                     sda_oe_reg <= ~shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            charger_limit_pkg::ST_RACK:
            begin
               if (scl_rise)
                  master_nack_reg <= clean_lines.sda;
               else if (scl_fall)
               begin
                  if (!master_nack_reg)
                  begin
                     // Next register, already one past the last byte sent
                     sda_oe_reg <= ~first_read_byte[7];
                     shift_reg <= {first_read_byte[6:0], 1'b0};
                     bit_cnt_reg <= charger_limit_pkg::FIRST_BIT_SENT;
                     state_reg <= charger_limit_pkg::ST_RDATA;
                  end
                  else
                     state_reg <= charger_limit_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_reg;

   // ----------------------------------------------------------------
   // Control byte
   // ----------------------------------------------------------------
   // Detection wins over a host write in the same cycle, since the host is
   // expected to write the limit only after detection has completed.
   always_ff @(posedge sys_clk)
   begin
      if (rst || register_reset)
         ctrl_reg <= charger_limit_pkg::LIMIT_CTRL_RESET;
      else
      begin
         if (host_write && ptr_reg == charger_limit_pkg::LIMIT_CTRL_OFFSET)
            ctrl_reg <= shift_reg;
         if (detect_done)
            ctrl_reg.input_current_limit_code <= detected_code;
         if (watchdog_expired)
            ctrl_reg.input_isolation_enable <= 1'b0;
      end
   end

   assign input_isolated_mode = ctrl_reg.input_isolation_enable;

   limit_decoder limit_map
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .limit_code(ctrl_reg.input_current_limit_code),
      .limit_ma(input_limit_ma)
   );

   // ----------------------------------------------------------------
   // Indicator pin
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         stat_oe_reg <= 1'b0;
      else
      begin
         unique case (ctrl_reg.indicator_pin_function_select)
            charger_limit_pkg::IND_FOLLOW_CHARGE: stat_oe_reg <= charge_active;
            charger_limit_pkg::IND_FOLLOW_CUSTOM: stat_oe_reg <= indicator_custom;
            default: stat_oe_reg <= 1'b0;
         endcase
      end
   end

   assign stat_out = 1'b0;
   assign stat_oe = stat_oe_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_reset_value_load: assert property (@(posedge sys_clk)
      rst |=> ctrl_reg == 8'h17)
      else $error("control byte not at its reset value");

   a_detect_code_load: assert property (@(posedge sys_clk) disable iff (rst)
      detect_done && !register_reset |=> ctrl_reg.input_current_limit_code == $past(detected_code))
      else $error("detection result not stored");

   a_host_isolation_write: assert property (@(posedge sys_clk) disable iff (rst)
      host_write && ptr_reg == 8'h00 && shift_reg[7] && !watchdog_expired && !register_reset
      |=> input_isolated_mode)
      else $error("isolation enable write lost");

   a_watchdog_isolation_clear: assert property (@(posedge sys_clk) disable iff (rst)
      watchdog_expired |=> !input_isolated_mode)
      else $error("watchdog did not clear isolation");

   a_stat_float_select: assert property (@(posedge sys_clk) disable iff (rst)
      ctrl_reg.indicator_pin_function_select[1] |=> !stat_oe)
      else $error("indicator pin driven while disabled");

   a_stat_follow_charge: assert property (@(posedge sys_clk) disable iff (rst)
      ctrl_reg.indicator_pin_function_select == 2'h0 |=> stat_oe == $past(charge_active))
      else $error("indicator pin does not follow charge state");

   a_write_ptr_step: assert property (@(posedge sys_clk) disable iff (rst)
      host_write && !bus_start && !bus_stop |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("write pointer did not advance");

   // The level is tied low, so the check also asks that some source wanted the pull
   a_open_drain_low: assert property (@(posedge sys_clk) disable iff (rst)
      stat_oe |-> stat_out == 1'b0 && ($past(charge_active) || $past(indicator_custom)))
      else $error("indicator pin pulled low without a source");

endmodule : charger_input_limit_register

// File: test/i2c_host_model.sv
// Behavioural serial bus host: open-drain clock and data drives with byte-level tasks.
// Assumes the testbench resolves the data wire with a pull-up and feeds it back.
`timescale 1ns/1ps
module i2c_host_model
(
   // Pacing clock
   input wire logic sys_clk,
   // Resolved data wire
   input wire logic sda_line,
   // Open-drain drives, high pulls low
   output logic scl_low,
   output logic sda_low,
   // Received byte report
   output logic rd_valid,
   output logic [7:0] rd_data
);
   // Phases well above four cycles so the slave's synchroniser delay never matters
   localparam int PHASE = 10;

   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end

   task automatic pause(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : pause

   // Also serves as repeated start: data is released while the clock is still low
   task automatic start_cond();
      sda_low = 1'b0;
      pause(PHASE);
      scl_low = 1'b0;
      pause(PHASE);
      sda_low = 1'b1;
      pause(PHASE);
      scl_low = 1'b1;
      pause(PHASE);
   endtask : start_cond

   task automatic stop_cond();
      sda_low = 1'b1;
      pause(PHASE);
      scl_low = 1'b0;
      pause(PHASE);
      sda_low = 1'b0;
      pause(PHASE);
   endtask : stop_cond

   task automatic xfer_bit(input logic b, output logic r);
      sda_low = ~b;
      pause(PHASE);
      scl_low = 1'b0;
      pause(PHASE);
      r = sda_line;
      scl_low = 1'b1;
      pause(PHASE);
   endtask : xfer_bit

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask : write_byte

   task automatic read_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         xfer_bit(1'b1, r);
         d[i] = r;
      end
      xfer_bit(~more, r);
      rd_data = d;
      rd_valid = 1'b1;
      pause(1);
      rd_valid = 1'b0;
   endtask : read_byte
endmodule : i2c_host_model

// File: test/tb_top.sv
// Testbench: reaches the control byte over the serial bus and through device events.
// Assumes pull-ups on both serial lines and on the indicator pin.
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV = 7'h0B;
   logic sys_clk, rst, scl_low, sda_low, rd_valid, sda_out, sda_oe, stat_out, stat_oe;
   logic detect_done, register_reset, watchdog_expired, charge_active, indicator_custom;
   logic input_isolated_mode, ack;
   logic [4:0] detected_code;
   logic [7:0] rd_data, mon_exp;
   logic [11:0] input_limit_ma;
   logic [7:0] exp_q[$];
   int err_count = 0;
   int checks_done = 0;
   int seed = 32'h8BD6;
   wire logic sda_line = ~(sda_low | (sda_oe & ~sda_out));

   charger_input_limit_register #(.SLAVE_ADDRESS(DEV)) i_charger_input_limit_register
   (
      .sys_clk(sys_clk), .rst(rst), .scl_in(~scl_low), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .detect_done(detect_done), .detected_code(detected_code), .register_reset(register_reset),
      .watchdog_expired(watchdog_expired), .charge_active(charge_active), .indicator_custom(indicator_custom),
      .stat_out(stat_out), .stat_oe(stat_oe), .input_isolated_mode(input_isolated_mode),
      .input_limit_ma(input_limit_ma)
   );
   i2c_host_model i_i2c_host_model
   (
      .sys_clk(sys_clk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low),
      .rd_valid(rd_valid), .rd_data(rd_data)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic cmp_val(input string name, input logic [11:0] exp, input logic [11:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : cmp_val

   task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected read byte: expected %h, seen %h", exp, got);
      end
   endtask : cmp_byte

   function automatic logic [11:0] exp_ma(input logic [4:0] code);
      return (code == 5'h1F) ? 12'hED8 : 12'h064 + 12'h064 * {7'h00, code};
   endfunction : exp_ma

   task automatic host_write(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input int n);
      i_i2c_host_model.start_cond();
      i_i2c_host_model.write_byte({DEV, 1'b0}, ack);
      cmp_val("address ack", 12'h001, {11'h000, ack});
      i_i2c_host_model.write_byte(ptr, ack);
      i_i2c_host_model.write_byte(d0, ack);
      if (n > 1)
         i_i2c_host_model.write_byte(d1, ack);
      i_i2c_host_model.stop_cond();
   endtask : host_write

   task automatic host_read(input logic [7:0] ptr, input int n);
      logic [7:0] d;
      i_i2c_host_model.start_cond();
      i_i2c_host_model.write_byte({DEV, 1'b0}, ack);
      i_i2c_host_model.write_byte(ptr, ack);
      i_i2c_host_model.start_cond();
      i_i2c_host_model.write_byte({DEV, 1'b1}, ack);
      for (int i = 0; i < n; i++)
         i_i2c_host_model.read_byte(i < n - 1, d);
      i_i2c_host_model.stop_cond();
   endtask : host_read

   task automatic pulse_detect(input logic [4:0] code);
      int r;
      detected_code = code;
      detect_done = 1'b1;
      @(negedge sys_clk);
      detect_done = 1'b0;
      r = $random(seed);
      // Code is only valid with the pulse, so scramble it afterwards
      detected_code = r[4:0];
      repeat (2) @(negedge sys_clk);
   endtask : pulse_detect

   task automatic close_out();
      if (exp_q.size() != 0)
      begin
         err_count++;
         $display("unexpected pending reads: expected 0, seen %0d", exp_q.size());
      end
      if (err_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // Oldest noted byte is matched against each byte the host receives
   always @(posedge sys_clk)
   begin
      if (rd_valid === 1'b1)
      begin
         mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
         cmp_byte(mon_exp, rd_data);
      end
   end

   initial
   begin
      repeat (90000) @(posedge sys_clk);
      err_count++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      int r;
      logic [4:0] code;
      rst = 1'b1;
      {detect_done, register_reset, watchdog_expired, charge_active, indicator_custom} = 5'h00;
      detected_code = 5'h00;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      repeat (6) @(negedge sys_clk);
      cmp_val("limit ma", 12'h960, input_limit_ma);
      cmp_val("isolated", 12'h000, {11'h000, input_isolated_mode});
      exp_q.push_back(8'h17);
      host_read(8'h00, 1);
      // Other variant's address gets no acknowledge
      i_i2c_host_model.start_cond();
      i_i2c_host_model.write_byte({7'h0A, 1'b0}, ack);
      cmp_val("foreign ack", 12'h000, {11'h000, ack});
      i_i2c_host_model.stop_cond();
      for (int c = 0; c < 32; c++)
      begin
         pulse_detect(c[4:0]);
         cmp_val("limit ma", exp_ma(c[4:0]), input_limit_ma);
      end
      host_write(8'h00, 8'h9E, 8'h00, 1);
      cmp_val("isolated", 12'h001, {11'h000, input_isolated_mode});
      cmp_val("limit ma", exp_ma(5'h1E), input_limit_ma);
      exp_q.push_back(8'h9E);
      host_read(8'h00, 1);
      r = $random(seed);
      code = r[4:0];
      pulse_detect(code);
      exp_q.push_back({3'b100, code});
      host_read(8'h00, 1);
      watchdog_expired = 1'b1;
      @(negedge sys_clk);
      watchdog_expired = 1'b0;
      repeat (2) @(negedge sys_clk);
      cmp_val("isolated", 12'h000, {11'h000, input_isolated_mode});
      exp_q.push_back({3'b000, code});
      host_read(8'h00, 1);
      host_write(8'hFF, 8'h55, 8'h0A, 2);
      exp_q.push_back(8'h0A);
      exp_q.push_back(8'h00);
      host_read(8'h00, 2);
      for (int s = 0; s < 4; s++)
      begin
         host_write(8'h00, {1'b0, s[1:0], 5'h17}, 8'h00, 1);
         for (int k = 0; k < 4; k++)
         begin
            r = $random(seed);
            charge_active = r[0];
            indicator_custom = r[1];
            repeat (3) @(negedge sys_clk);
            cmp_val("stat oe", {11'h000, s == 0 ? r[0] : (s == 1 ? r[1] : 1'b0)}, {11'h000, stat_oe});
            cmp_val("stat out", 12'h000, {11'h000, stat_out});
         end
      end
      register_reset = 1'b1;
      @(negedge sys_clk);
      register_reset = 1'b0;
      repeat (3) @(negedge sys_clk);
      cmp_val("limit ma", 12'h960, input_limit_ma);
      exp_q.push_back(8'h17);
      host_read(8'h00, 1);
      repeat (4) @(negedge sys_clk);
      close_out();
   end
endmodule : tb_top
